// File: core/pcc_mod_if.sv
// Signals passed between the top and one compare/capture unit
`timescale 1ns/100ps
interface pcc_mod_if;
    import pcc_pkg::*;
    logic [MODE_WIDTH-1:0] mode;      // Mode register contents
    logic [15:0]           value;     // Compare/capture value
    logic [15:0]           count;     // Shared counter value
    logic                  pin_sync;  // Synchronised capture input
    logic                  event_hit; // Match or capture this cycle
    logic                  capture;   // Capture this cycle
    logic                  out_level; // Module output pin level

    // Top side drives configuration and reads events
    modport core (output mode, value, count, pin_sync,
                  input  event_hit, capture, out_level);
    // Unit side evaluates one module
    modport unit (input  mode, value, count, pin_sync,
                  output event_hit, capture, out_level);
endinterface : pcc_mod_if

// File: core/pcc_pkg.sv
// Constants, register map and field layout for the capture/compare block
// Notes on behaviour
// R01: Overflow flag with enable requests an interrupt
// R02: Only software clears the overflow flag
// R03: Five modules, each with own event flag
// R04: Event flags stay set until software clears
// R05: Each module has seven-bit mode register
// R06: Mode bit 0 lets event flag interrupt
// R07: Mode bit 1 selects pulse width modulation
// R08: Mode bit 2 inverts output on match
// R09: Mode bit 3 sets event flag on match
// R10: Bit 4 falling edge, bit 5 rising capture
// R11: Both edge bits capture on every transition
// R12: Mode bit 6 enables the comparator
// R13: High and low bytes hold 16-bit value
// R14: In modulation mode value sets duty cycle
// R15: Capture copies counter in detecting clock
// R16: Capture input synchronised, samples compared
package pcc_pkg;

    // Number of compare/capture modules
    localparam int NUM_MODULES = 5;
    // Width of a mode register
    localparam int MODE_WIDTH  = 7;

    // Special function register addresses
    localparam logic [7:0] ADDR_CTRL = 8'hD8; // Counter control register
    localparam logic [7:0] ADDR_COUNTER_MODE_REG = 8'hD9; // Counter mode register
    // Per-module mode registers
    localparam logic [7:0] ADDR_MODE [NUM_MODULES] =
        '{8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE};
    // Per-module value low bytes
    localparam logic [7:0] ADDR_VAL_LO [NUM_MODULES] =
        '{8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE};
    // Per-module value high bytes
    localparam logic [7:0] ADDR_VAL_HI [NUM_MODULES] =
        '{8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE};

    // Counter control register fields
    localparam int CTRL_OVF_BIT = 7; // Counter overflow flag
    // Counter mode register fields
    localparam int COUNTER_MODE_REG_OVF_IRQ_BIT = 0; // Overflow interrupt enable

    // Module mode register fields
    localparam int MODE_IRQ_EN_BIT  = 0; // Event flag may interrupt
    localparam int MODE_PWM_BIT     = 1; // Pulse width modulation
    localparam int MODE_FLIP_BIT    = 2; // Invert output on match
    localparam int MODE_MATCH_BIT   = 3; // Match sets event flag
    localparam int MODE_CAPTURE_FALLING_EN_BIT    = 4; // Capture on falling edge
    localparam int MODE_CAPTURE_RISING_EN_BIT    = 5; // Capture on rising edge
    localparam int MODE_COMPARATOR_ENABLE_BIT    = 6; // Comparator enable

    // Values after reset and for unmapped reads
    localparam logic [7:0]            RST_BYTE  = 8'h00;
    localparam logic [MODE_WIDTH-1:0] RST_MODE  = 7'h00;
    localparam logic [7:0]            RD_UNMAPPED = 8'h00;
    // Low byte value at which modulation reloads the compare byte
    localparam logic [7:0]            PWM_WRAP  = 8'hFF;

endpackage : pcc_pkg

// File: core/pcc_top.sv
// Capture/compare array: registers, flags, interrupt, five units
`timescale 1ns/100ps
module pcc_top
    import pcc_pkg::*;
(
    input  wire logic                   ref_clk,           // System clock
    input  wire logic                   arst_n,            // Async reset
    input  wire logic [7:0]             sfr_addr,          // SFR address
    input  wire logic [7:0]             sfr_wdata,         // Write data
    input  wire logic                   sfr_wr,            // Write strobe
    input  wire logic                   sfr_rd,            // Read strobe
    output logic      [7:0]             sfr_rdata,         // Read data
    input  wire logic [15:0]            count_value,       // Shared counter
    input  wire logic                   count_overflow,    // Counter wrap
    input  wire logic [NUM_MODULES-1:0] capture_pin,       // Capture pins
    output logic      [NUM_MODULES-1:0] module_output_pin, // Output pins
    output logic                        irq_req            // Interrupt
);
    // Reset synchroniser
    logic rst_meta_q;  // First reset stage
    logic rst_n_q;     // Reset used by the design

    // Capture pin synchroniser
    logic [NUM_MODULES-1:0] cap_meta_q; // First stage, read by stage two
    logic [NUM_MODULES-1:0] cap_sync_q; // Second stage

    // Register state
    logic                   ovf_flag_q;  // Counter overflow flag
    logic [NUM_MODULES-1:0] event_q;     // Module event flags
    logic [7:0]             counter_mode_reg_q;      // Counter mode register
    logic [MODE_WIDTH-1:0]  mode_q   [NUM_MODULES]; // Mode registers
    logic [7:0]             val_lo_q [NUM_MODULES]; // Value low bytes
    logic [7:0]             val_hi_q [NUM_MODULES]; // Value high bytes
    logic [7:0]             rdata_q;     // Read data register
    logic                   irq_q;       // Interrupt request register

    // Decode and per-module status
    logic                   ctrl_wr;     // Control register write
    logic                   counter_mode_reg_wr;     // Counter mode write
    logic [NUM_MODULES-1:0] mod_event;   // Events from units
    logic [NUM_MODULES-1:0] mod_capture; // Captures from units
    logic [NUM_MODULES-1:0] mod_out;     // Unit output levels
    logic [NUM_MODULES-1:0] mod_irq_en;  // Per-module irq enables
    logic [7:0]             rd_mux;      // Selected read value

    // Interface to each unit
    pcc_mod_if mif [NUM_MODULES] ();

    // Release reset through two flops
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_meta_q <= 1'b0;
            rst_n_q    <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q    <= rst_meta_q;
        end
    end

    // Capture pins pass two flops before any logic
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            cap_meta_q <= '0;
            cap_sync_q <= '0;
        end else begin
            cap_meta_q <= capture_pin;
            cap_sync_q <= cap_meta_q; // R16
        end
    end

    // Register write decode
    assign ctrl_wr = sfr_wr && (sfr_addr == ADDR_CTRL);
    assign counter_mode_reg_wr = sfr_wr && (sfr_addr == ADDR_COUNTER_MODE_REG);

    // Overflow flag: counter sets, only software clears
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ovf_flag_q <= 1'b0;
        end else if (count_overflow) begin
            // Set wins over a clear in the same cycle
            ovf_flag_q <= 1'b1;
        end else if (ctrl_wr) begin
            ovf_flag_q <= sfr_wdata[CTRL_OVF_BIT]; // R02
        end
    end

    // Module event flags: units set, only software clears
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            event_q <= '0;
        end else if (ctrl_wr) begin
            // Hardware set wins over a software clear
            event_q <= mod_event | sfr_wdata[NUM_MODULES-1:0]; // R04
        end else begin
            event_q <= event_q | mod_event; // R03
        end
    end

    // Counter mode register
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            counter_mode_reg_q <= RST_BYTE;
        end else if (counter_mode_reg_wr) begin
            counter_mode_reg_q <= sfr_wdata;
        end
    end

    // Per-module registers and unit instances
    for (genvar i = 0; i < NUM_MODULES; i++) begin : g_mod
        logic mode_wr; // This module's mode write
        logic lo_wr;   // This module's low byte write
        logic hi_wr;   // This module's high byte write
        logic reload;  // Modulation reload of the duty byte

        assign mode_wr = sfr_wr && (sfr_addr == ADDR_MODE[i]);
        assign lo_wr   = sfr_wr && (sfr_addr == ADDR_VAL_LO[i]);
        assign hi_wr   = sfr_wr && (sfr_addr == ADDR_VAL_HI[i]);
        // Duty byte takes the high byte as the low count wraps
        assign reload  = mode_q[i][MODE_PWM_BIT]
                      && (count_value[7:0] == PWM_WRAP); // R14

        // Seven-bit mode register
        always_ff @(posedge ref_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                mode_q[i] <= RST_MODE;
            end else if (mode_wr) begin
                mode_q[i] <= sfr_wdata[MODE_WIDTH-1:0]; // R05
            end
        end

        // Low byte: capture first, then software, then reload
        always_ff @(posedge ref_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                val_lo_q[i] <= RST_BYTE;
            end else if (mod_capture[i]) begin
                val_lo_q[i] <= count_value[7:0]; // R15
            end else if (lo_wr) begin
                val_lo_q[i] <= sfr_wdata; // R13
            end else if (reload) begin
                val_lo_q[i] <= val_hi_q[i]; // R14
            end
        end

        // High byte: capture first, then software
        always_ff @(posedge ref_clk or negedge rst_n_q) begin
            if (!rst_n_q) begin
                val_hi_q[i] <= RST_BYTE;
            end else if (mod_capture[i]) begin
                val_hi_q[i] <= count_value[15:8]; // R15
            end else if (hi_wr) begin
                val_hi_q[i] <= sfr_wdata; // R13
            end
        end

        // Unit inputs
        assign mif[i].mode     = mode_q[i];
        assign mif[i].value    = {val_hi_q[i], val_lo_q[i]}; // R13
        assign mif[i].count    = count_value;
        assign mif[i].pin_sync = cap_sync_q[i];
        // Unit outputs
        assign mod_event[i]    = mif[i].event_hit;
        assign mod_capture[i]  = mif[i].capture;
        assign mod_out[i]      = mif[i].out_level;
        assign mod_irq_en[i]   = mode_q[i][MODE_IRQ_EN_BIT];

        // Compare/capture unit
        pcc_unit u_unit (
            .clk   (ref_clk),
            .rst_n (rst_n_q),
            .u     (mif[i])
        );
    end

    // Output pins come straight from the unit flops
    assign module_output_pin = mod_out;

    // Interrupt request from overflow or any enabled event
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= (ovf_flag_q && counter_mode_reg_q[COUNTER_MODE_REG_OVF_IRQ_BIT]) // R01
                  || |(event_q & mod_irq_en); // R06
        end
    end
    assign irq_req = irq_q;

    // Read multiplexer; unmapped addresses read zero
    always_comb begin
        rd_mux = RD_UNMAPPED;
        if (sfr_addr == ADDR_CTRL) begin
            rd_mux = RD_UNMAPPED;
            rd_mux[CTRL_OVF_BIT] = ovf_flag_q;
            rd_mux[NUM_MODULES-1:0] = event_q;
        end else if (sfr_addr == ADDR_COUNTER_MODE_REG) begin
            rd_mux = counter_mode_reg_q;
        end else begin
            for (int k = 0; k < NUM_MODULES; k++) begin
                if (sfr_addr == ADDR_MODE[k]) begin
                    rd_mux = {1'b0, mode_q[k]};
                end else if (sfr_addr == ADDR_VAL_LO[k]) begin
                    rd_mux = val_lo_q[k];
                end else if (sfr_addr == ADDR_VAL_HI[k]) begin
                    rd_mux = val_hi_q[k];
                end
            end
        end
    end

    // Read data register, held between reads
    always_ff @(posedge ref_clk or negedge rst_n_q) begin
        if (!rst_n_q) begin
            rdata_q <= RST_BYTE;
        end else if (sfr_rd) begin
            rdata_q <= rd_mux;
        end
    end
    assign sfr_rdata = rdata_q;

    // Checks on the behaviour above
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n_q);

    // Flags that software keeps this cycle
    logic [NUM_MODULES-1:0] keep_mask; // Event flags not being cleared
    assign keep_mask = event_q & (ctrl_wr ? sfr_wdata[NUM_MODULES-1:0]
                                          : {NUM_MODULES{1'b1}});

    a_ovf_irq_req: assert property ( // R01
        ovf_flag_q && counter_mode_reg_q[COUNTER_MODE_REG_OVF_IRQ_BIT] |=> irq_req)
        else $error("overflow flag with enable gave no interrupt");

    a_ovf_flag_hold: assert property ( // R02
        ovf_flag_q && !ctrl_wr |=> ovf_flag_q)
        else $error("overflow flag cleared without software");

    a_ovf_flag_set: assert property ( // R02
        count_overflow |=> ovf_flag_q)
        else $error("counter overflow did not set the flag");

    a_event_hold: assert property ( // R04
        1'b1 |=> ((event_q & $past(keep_mask)) == $past(keep_mask)))
        else $error("event flag cleared by hardware");

    a_idle_irq_low: assert property ( // R06
        !ovf_flag_q && !(|event_q) |=> !irq_req)
        else $error("interrupt without a pending flag");

    a_rdata_hold: assert property ( // R13
        !sfr_rd |=> $stable(sfr_rdata))
        else $error("read data changed without a read");

    a_ovf_flag_clear: assert property ( // R02
        ctrl_wr && !sfr_wdata[CTRL_OVF_BIT] && !count_overflow
        |=> !ovf_flag_q)
        else $error("software write left overflow flag set");

    a_event_clear: assert property ( // R04
        ctrl_wr && !(|(sfr_wdata[NUM_MODULES-1:0] | mod_event))
        |=> !(|event_q))
        else $error("software write left an event flag set");

    for (genvar j = 0; j < NUM_MODULES; j++) begin : g_chk
        // Comparator starts matching with match enable set
        sequence s_match_rise;
            $rose(mode_q[j][MODE_COMPARATOR_ENABLE_BIT]
                  && (count_value == {val_hi_q[j], val_lo_q[j]}))
            && mode_q[j][MODE_MATCH_BIT];
        endsequence
        // Comparator starts matching in toggle mode
        sequence s_flip_rise;
            $rose(mode_q[j][MODE_COMPARATOR_ENABLE_BIT]
                  && (count_value == {val_hi_q[j], val_lo_q[j]}))
            && mode_q[j][MODE_FLIP_BIT] && !mode_q[j][MODE_PWM_BIT];
        endsequence

        a_event_set: assert property ( // R03
            mod_event[j] |=> event_q[j])
            else $error("module event did not set its flag");

        a_match_flag: assert property ( // R09
            s_match_rise |=> event_q[j])
            else $error("enabled match did not set the event flag");

        a_toggle_pin: assert property ( // R08
            s_flip_rise |=> module_output_pin[j] != $past(mod_out[j]))
            else $error("output did not invert on match");

        a_capture_load: assert property ( // R15
            mod_capture[j] |=>
            {val_hi_q[j], val_lo_q[j]} == $past(count_value))
            else $error("capture did not load the counter value");

        a_both_edges: assert property ( // R11
            $changed(cap_sync_q[j]) && mode_q[j][MODE_CAPTURE_FALLING_EN_BIT]
            && mode_q[j][MODE_CAPTURE_RISING_EN_BIT] && $stable(mode_q[j])
            |-> mod_capture[j])
            else $error("transition missed with both edges enabled");

        a_capture_cause: assert property ( // R16
            mod_capture[j] |-> $changed(cap_sync_q[j]))
            else $error("capture without a synchronised edge");

        a_module_irq: assert property ( // R06
            event_q[j] && mode_q[j][MODE_IRQ_EN_BIT] |=> irq_req)
            else $error("enabled module event gave no interrupt");

        a_pwm_level: assert property ( // R14
            mode_q[j][MODE_PWM_BIT] && mode_q[j][MODE_COMPARATOR_ENABLE_BIT]
            |=> module_output_pin[j]
                == ($past(count_value[7:0]) >= $past(val_lo_q[j])))
            else $error("modulated output level wrong");

        // Low count byte wraps in modulation with no competing load
        sequence s_pwm_wrap;
            mode_q[j][MODE_PWM_BIT] && (count_value[7:0] == PWM_WRAP)
            && !mod_capture[j] && !g_mod[j].lo_wr;
        endsequence

        a_pwm_reload: assert property ( // R14
            s_pwm_wrap |=> val_lo_q[j] == $past(val_hi_q[j]))
            else $error("duty byte not reloaded at the wrap");

        a_no_capture: assert property ( // R10
            !mode_q[j][MODE_CAPTURE_FALLING_EN_BIT] && !mode_q[j][MODE_CAPTURE_RISING_EN_BIT]
            |-> !mod_capture[j])
            else $error("capture with both edges disabled");

        a_pin_quiet: assert property ( // R12
            !mode_q[j][MODE_COMPARATOR_ENABLE_BIT] |=> $stable(module_output_pin[j]))
            else $error("output moved with comparator off");

        a_value_hold: assert property ( // R13
            !mod_capture[j] && !g_mod[j].lo_wr && !g_mod[j].hi_wr
            && !mode_q[j][MODE_PWM_BIT]
            |=> $stable({val_hi_q[j], val_lo_q[j]}))
            else $error("value bytes changed without cause");

        a_mode_write: assert property ( // R05
            g_mod[j].mode_wr
            |=> mode_q[j] == $past(sfr_wdata[MODE_WIDTH-1:0]))
            else $error("mode register write not stored");
    end

endmodule : pcc_top

// File: core/pcc_unit.sv
// One compare/capture unit: edge detect, comparator, output pin
`timescale 1ns/100ps
module pcc_unit
    import pcc_pkg::*;
(
    input  wire logic clk,   // System clock
    input  wire logic rst_n, // Synchronised reset, active low
    pcc_mod_if.unit   u      // Link to the top
);
    logic prev_q;       // Previous capture input sample
    logic match_prev_q; // Comparator result last cycle
    logic out_q;        // Output pin level
    logic match_now;    // Comparator hit this cycle
    logic match_rise;   // First cycle of a hit
    logic rise;         // Rising edge seen
    logic fall;         // Falling edge seen

    // Comparator only works when enabled
    assign match_now  = u.mode[MODE_COMPARATOR_ENABLE_BIT] && (u.count == u.value); // R12
    assign match_rise = match_now && !match_prev_q;
    // Compare successive synchronised samples
    assign rise = u.pin_sync && !prev_q;  // R16
    assign fall = !u.pin_sync && prev_q;  // R16
    // Either enabled edge captures; both bits give every transition
    assign u.capture = (rise && u.mode[MODE_CAPTURE_RISING_EN_BIT])
                     || (fall && u.mode[MODE_CAPTURE_FALLING_EN_BIT]); // R10 R11
    // Event from capture or enabled match
    assign u.event_hit = u.capture
                       || (match_rise && u.mode[MODE_MATCH_BIT]); // R09
    assign u.out_level = out_q;

    // Input and comparator history
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q       <= 1'b0;
            match_prev_q <= 1'b0;
        end else begin
            prev_q       <= u.pin_sync;
            match_prev_q <= match_now;
        end
    end

    // Output pin: modulation level or toggle on match
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_q <= 1'b0;
        end else if (u.mode[MODE_PWM_BIT] && u.mode[MODE_COMPARATOR_ENABLE_BIT]) begin
            // Low while counter is below the duty byte
            out_q <= (u.count[7:0] >= u.value[7:0]); // R07 R14
        end else if (u.mode[MODE_FLIP_BIT] && match_rise) begin
            out_q <= ~out_q; // R08
        end
    end

endmodule : pcc_unit

// File: tb/pcc_pin_model.sv
// Behavioural model of the capture inputs and the output pin loads
`timescale 1ns/100ps
module pcc_pin_model
    import pcc_pkg::*;
(
    input  wire logic                   clk,       // System clock
    input  wire logic [NUM_MODULES-1:0] want,      // Levels asked by bench
    input  wire logic [NUM_MODULES-1:0] drive_pin, // Module outputs
    output logic      [NUM_MODULES-1:0] cap_pin,   // Capture inputs
    output logic      [NUM_MODULES-1:0] seen       // Sampled outputs
);
    // Pins start low, as a quiet source would hold them
    initial cap_pin = '0;

    // Source moves just after an edge, unrelated to the sampling edge
    always @(posedge clk) begin
        cap_pin <= #1 want;
        seen    <= drive_pin;
    end
endmodule : pcc_pin_model

// File: tb/testbench.sv
// Self-checking bench for the capture/compare array
`timescale 1ns/100ps
module testbench;
    import pcc_pkg::*;
    logic                   ref_clk;        // System clock
    logic                   arst_n;         // Async reset
    logic [7:0]             sfr_addr;       // Register address
    logic [7:0]             sfr_wdata;      // Write data
    logic                   sfr_wr;         // Write strobe
    logic                   sfr_rd;         // Read strobe
    logic [7:0]             sfr_rdata;      // Read data
    logic [15:0]            count_value;    // Counter stimulus
    logic                   count_overflow; // Counter wrap pulse
    logic [NUM_MODULES-1:0] pin_want;       // Levels for the model
    logic [NUM_MODULES-1:0] capture_pin;    // Capture pins
    logic [NUM_MODULES-1:0] module_output_pin; // Output pins
    logic [NUM_MODULES-1:0] out_seen;       // Outputs seen by model
    logic                   irq_req;        // Interrupt request
    logic [7:0]             exp_q [$];      // Expected read data
    logic                   rd_seen;        // Read taken last edge
    logic [31:0]            lfsr;           // Random source
    logic [7:0]             mode_b;         // Mode under test
    logic                   hit;            // Capture expected
    logic [15:0]            vals [NUM_MODULES]; // Value byte mirror
    int                     fails;          // Mismatch count
    int                     samples_checked; // Comparison count

    pcc_top i_pcc_top (.ref_clk(ref_clk), .arst_n(arst_n),
        .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata), .sfr_wr(sfr_wr),
        .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata),
        .count_value(count_value), .count_overflow(count_overflow),
        .capture_pin(capture_pin),
        .module_output_pin(module_output_pin), .irq_req(irq_req));

    pcc_pin_model i_pcc_pin_model (.clk(ref_clk), .want(pin_want),
        .drive_pin(module_output_pin), .cap_pin(capture_pin),
        .seen(out_seen));

    // Free-running 125 MHz clock
    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    // Random step
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : next_rand

    // Wait edges, then step off the sampling edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : tick

    // One-cycle register write
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        tick(1);
        sfr_wr    = 1'b0;
        tick(1);
    endtask : wr

    // One-cycle register read, result noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        tick(1);
        sfr_rd   = 1'b0;
        tick(1);
    endtask : rd

    // Compare and count
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            fails++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask : chk

    // Read data monitor, one cycle after each read edge
    always @(posedge ref_clk) begin
        if (rd_seen === 1'b1 && exp_q.size() > 0) begin
            chk(sfr_rdata, exp_q.pop_front());
        end
        rd_seen <= sfr_rd;
    end

    // Verdict and end of run
    task automatic wrap_up();
        $display("checks %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Hang guard
    initial begin
        repeat (20000) @(posedge ref_clk);
        fails++;
        wrap_up();
    end

    // Main sequence
    initial begin
        arst_n = 1'b0;
        {sfr_addr, sfr_wdata, sfr_wr, sfr_rd} = '0;
        count_value = 16'h0000;
        count_overflow = 1'b0;
        pin_want = '0;
        rd_seen = 1'b0;
        lfsr = 32'h0000_9e29;
        fails = 0;
        samples_checked = 0;
        tick(10);
        arst_n = 1'b1;
        tick(4);
        // Reset values, unmapped place refused
        for (int i = 0; i < NUM_MODULES; i++) begin
            rd(ADDR_VAL_LO[i], RST_BYTE);
            rd(ADDR_VAL_HI[i], RST_BYTE);
        end
        wr(8'h00, 8'hFF);
        rd(8'h00, RD_UNMAPPED);
        $display("test reset values done");
        // Value bytes hold a 16-bit word per module
        for (int i = 0; i < NUM_MODULES; i++) begin
            lfsr = next_rand(lfsr);
            vals[i] = lfsr[15:0];
            wr(ADDR_VAL_LO[i], vals[i][7:0]);
            wr(ADDR_VAL_HI[i], vals[i][15:8]);
            rd(ADDR_VAL_LO[i], vals[i][7:0]);
            rd(ADDR_VAL_HI[i], vals[i][15:8]);
        end
        // Mode register keeps seven bits
        lfsr = next_rand(lfsr);
        wr(ADDR_MODE[3], lfsr[7:0] | 8'h80);
        rd(ADDR_MODE[3], {1'b0, lfsr[6:0]});
        wr(ADDR_MODE[3], RST_BYTE);
        $display("test register access done");
        // Rising, falling and both-edge capture on modules 0..2
        for (int m = 0; m < 3; m++) begin
            mode_b = (m == 0) ? 8'h20 : (m == 1) ? 8'h10 : 8'h30;
            wr(ADDR_MODE[m], mode_b);
            for (int e = 0; e < 2; e++) begin
                wr(ADDR_CTRL, 8'h00);
                lfsr = next_rand(lfsr);
                count_value = lfsr[15:0];
                hit = mode_b[5-e];
                if (hit) vals[m] = count_value;
                pin_want[m] = ~pin_want[m];
                tick(6);
                rd(ADDR_CTRL, {7'h00, hit} << m);
                rd(ADDR_VAL_HI[m], vals[m][15:8]);
                rd(ADDR_VAL_LO[m], vals[m][7:0]);
            end
        end
        $display("test capture done");
        // Match toggles output, sets flag, interrupts
        count_value = 16'h0000;
        wr(ADDR_VAL_HI[1], 8'h12);
        wr(ADDR_VAL_LO[1], 8'h34);
        wr(ADDR_MODE[1], 8'h4D);
        wr(ADDR_CTRL, 8'h00);
        count_value = 16'h1234;
        tick(1);
        count_value = 16'h1235;
        tick(3);
        chk({7'h00, out_seen[1]}, 8'h01);
        chk({7'h00, irq_req}, 8'h01);
        tick(20);
        rd(ADDR_CTRL, 8'h02);
        wr(ADDR_CTRL, 8'h00);
        tick(2);
        chk({7'h00, irq_req}, 8'h00);
        // Comparator off: a match does nothing
        wr(ADDR_MODE[1], 8'h0D);
        count_value = 16'h1234;
        tick(1);
        count_value = 16'h0000;
        tick(3);
        chk({7'h00, out_seen[1]}, 8'h01);
        rd(ADDR_CTRL, 8'h00);
        $display("test compare done");
        // Overflow flag, its interrupt, software clear
        wr(ADDR_COUNTER_MODE_REG, 8'h01);
        rd(ADDR_COUNTER_MODE_REG, 8'h01);
        count_overflow = 1'b1;
        tick(1);
        count_overflow = 1'b0;
        tick(2);
        chk({7'h00, irq_req}, 8'h01);
        tick(30);
        rd(ADDR_CTRL, 8'h80);
        wr(ADDR_COUNTER_MODE_REG, 8'h00);
        tick(2);
        chk({7'h00, irq_req}, 8'h00);
        wr(ADDR_CTRL, 8'h00);
        rd(ADDR_CTRL, 8'h00);
        $display("test overflow done");
        // Modulation: duty byte against counter low byte
        wr(ADDR_VAL_HI[2], 8'h80);
        wr(ADDR_VAL_LO[2], 8'h80);
        wr(ADDR_MODE[2], 8'h42);
        count_value = 16'h0090;
        tick(3);
        chk({7'h00, out_seen[2]}, 8'h01);
        count_value = 16'h0010;
        tick(3);
        chk({7'h00, out_seen[2]}, 8'h00);
        // Reload of the duty byte at the low byte wrap
        wr(ADDR_VAL_HI[2], 8'h20);
        count_value = 16'h00FF;
        tick(1);
        count_value = 16'h0030;
        tick(3);
        chk({7'h00, out_seen[2]}, 8'h01);
        $display("test modulation done");
        wrap_up();
    end
endmodule : testbench
